// ---- core/atwrc_top.sv ----
// Top of the converter control block: special-function registers,
// converter clock, result capture, window flag and reference controls.
// Assumes an 8-bit register bus on the system clock; the analog core
// returns its done strobe and result from outside this clock domain.
`timescale 1ns/10ps
`default_nettype none

module atwrc_top (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // Register bus
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  output var  logic [7:0]  o_sfr_rdata,
  // Conversion start event
  input  wire logic        i_conv_start,
  // Analog converter core
  input  wire logic        i_conv_done,
  input  wire logic [15:0] i_conv_result,
  output var  logic        o_conv_clk,
  output var  logic        o_conv_power_on,
  output var  logic        o_conv_track,
  output var  logic        o_conv_begin,
  // Window detector
  output var  logic        o_window_flag,
  // Reference and bias
  output var  logic        o_ref_level_sel,
  output var  logic        o_ref_source_sel,
  output var  logic        o_temp_sensor_on,
  output var  logic        o_bias_on,
  output var  logic        o_ref_buffer_on,
  output var  logic        o_zero_tc_bias_on
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0]  track_sel_r;
  logic [5:0]  ref_ctrl_r;
  logic        conv_en_r;
  logic        burst_en_r;
  logic [15:0] upper_r;
  logic [15:0] lower_r;
  logic [15:0] result_r;
  logic [2:0]  div_cnt_r;
  logic [2:0]  div_cnt_nxt;
  logic        done_meta_r;
  logic        done_sync_r;
  logic        done_dly_r;
  logic [15:0] res_meta_r;
  logic [15:0] res_sync_r;
  logic        capture;
  logic        win_flag;
  logic        win_clear;
  logic        wr_track;
  logic        wr_ref;
  logic        wr_ctrl;
  logic [7:0]  rd_mux;
  logic        ztc_need;

  atwrc_seq_if seq_bus ();

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  assign wr_track = i_sfr_wr && (i_sfr_addr == atwrc_pkg::ADDR_TRACK_SEL);
  assign wr_ref   = i_sfr_wr && (i_sfr_addr == atwrc_pkg::ADDR_REF_CTRL);
  assign wr_ctrl  = i_sfr_wr && (i_sfr_addr == atwrc_pkg::ADDR_CONV_CTRL);

  // Writing zero to the flag bit clears it; writing one leaves it
  assign win_clear = wr_ctrl && !i_sfr_wdata[atwrc_pkg::WIN_BIT];

  // ----------------------------------------------------------------------
  // Tracking select register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      track_sel_r <= atwrc_pkg::TRACK_SEL_RST;
    else if (wr_track)
      track_sel_r <= i_sfr_wdata;
  end

  // ----------------------------------------------------------------------
  // Reference control register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      ref_ctrl_r <= atwrc_pkg::REF_CTRL_RST[5:0];
    else if (wr_ref)
      ref_ctrl_r <= i_sfr_wdata[5:0] &
                    atwrc_pkg::REF_WR_MASK[5:0];
  end

  // ----------------------------------------------------------------------
  // Converter control register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      conv_en_r  <= 1'b0;
      burst_en_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      conv_en_r  <= i_sfr_wdata[atwrc_pkg::EN_BIT];
      burst_en_r <= i_sfr_wdata[atwrc_pkg::BURST_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Window limit registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      upper_r <= atwrc_pkg::UPPER_RST;
    else if (i_sfr_wr && i_sfr_addr == atwrc_pkg::ADDR_UPPER_HI)
      upper_r[15:8] <= i_sfr_wdata;
    else if (i_sfr_wr && i_sfr_addr == atwrc_pkg::ADDR_UPPER_LO)
      upper_r[7:0] <= i_sfr_wdata;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      lower_r <= atwrc_pkg::LOWER_RST;
    else if (i_sfr_wr && i_sfr_addr == atwrc_pkg::ADDR_LOWER_HI)
      lower_r[15:8] <= i_sfr_wdata;
    else if (i_sfr_wr && i_sfr_addr == atwrc_pkg::ADDR_LOWER_LO)
      lower_r[7:0] <= i_sfr_wdata;
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb
  begin
    rd_mux = atwrc_pkg::UNMAPPED_READ;
    unique case (i_sfr_addr)
      atwrc_pkg::ADDR_TRACK_SEL: rd_mux = track_sel_r;
      atwrc_pkg::ADDR_REF_CTRL:  rd_mux = {2'h0, ref_ctrl_r};
      atwrc_pkg::ADDR_CONV_CTRL:
      begin
        rd_mux[atwrc_pkg::EN_BIT]    = conv_en_r;
        rd_mux[atwrc_pkg::BURST_BIT] = burst_en_r;
        rd_mux[atwrc_pkg::BUSY_BIT]  = seq_bus.busy;
        rd_mux[atwrc_pkg::WIN_BIT]   = win_flag;
      end
      atwrc_pkg::ADDR_UPPER_HI:  rd_mux = upper_r[15:8];
      atwrc_pkg::ADDR_UPPER_LO:  rd_mux = upper_r[7:0];
      atwrc_pkg::ADDR_LOWER_HI:  rd_mux = lower_r[15:8];
      atwrc_pkg::ADDR_LOWER_LO:  rd_mux = lower_r[7:0];
      atwrc_pkg::ADDR_RESULT_HI: rd_mux = result_r[15:8];
      atwrc_pkg::ADDR_RESULT_LO: rd_mux = result_r[7:0];
      default:                   rd_mux = atwrc_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      o_sfr_rdata <= 8'h00;
    else if (i_sfr_rd)
      o_sfr_rdata <= rd_mux;
    else
      o_sfr_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------------
  // Converter clock divider
  // ----------------------------------------------------------------------
  assign div_cnt_nxt = (div_cnt_r == atwrc_pkg::CONV_DIV_M1) ?
                       3'h0 : div_cnt_r + 3'h1;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      div_cnt_r  <= 3'h0;
      o_conv_clk <= 1'b0;
    end
    else
    begin
      div_cnt_r  <= div_cnt_nxt;
      o_conv_clk <= (div_cnt_nxt >= atwrc_pkg::CONV_DIV_HALF);
    end
  end

  // ----------------------------------------------------------------------
  // Done strobe and result synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      done_meta_r <= 1'b0;
      done_sync_r <= 1'b0;
      done_dly_r  <= 1'b0;
      res_meta_r  <= 16'h0000;
      res_sync_r  <= 16'h0000;
    end
    else
    begin
      done_meta_r <= i_conv_done;
      done_sync_r <= done_meta_r;
      done_dly_r  <= done_sync_r;
      res_meta_r  <= i_conv_result;
      res_sync_r  <= res_meta_r;
    end
  end

  // Result is held stable by the core while done is high
  assign capture = done_sync_r && !done_dly_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      result_r <= 16'h0000;
    else if (capture)
      result_r <= res_sync_r;
  end

  // ----------------------------------------------------------------------
  // Window comparator
  // ----------------------------------------------------------------------
  atwrc_window u_window (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_load    (capture),
    .i_result  (res_sync_r),
    .i_upper   (upper_r),
    .i_lower   (lower_r),
    .i_clear   (win_clear),
    .o_flag    (win_flag)
  );

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      o_window_flag <= 1'b0;
    else
      o_window_flag <= win_flag;
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  assign seq_bus.enable    = conv_en_r;
  assign seq_bus.burst     = burst_en_r;
  assign seq_bus.pwr_field = track_sel_r[atwrc_pkg::PWR_LSB +: 4];
  assign seq_bus.tm_field  = track_sel_r[atwrc_pkg::TM_LSB +: 2];
  assign seq_bus.tk_field  = track_sel_r[atwrc_pkg::TK_LSB +: 2];
  assign seq_bus.conv_tick = (div_cnt_r == atwrc_pkg::CONV_DIV_M1);
  assign seq_bus.start     = i_conv_start;
  assign seq_bus.done      = capture;

  atwrc_seq u_seq (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .bus       (seq_bus)
  );

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      o_conv_power_on <= 1'b0;
      o_conv_track    <= 1'b0;
      o_conv_begin    <= 1'b0;
    end
    else
    begin
      o_conv_power_on <= seq_bus.power_on;
      o_conv_track    <= seq_bus.track;
      o_conv_begin    <= seq_bus.begin_conv;
    end
  end

  // ----------------------------------------------------------------------
  // Reference and bias controls
  // ----------------------------------------------------------------------
  // Zero-TC bias is needed whenever any analog consumer is active
  assign ztc_need = seq_bus.power_on ||
                    ref_ctrl_r[atwrc_pkg::TEMP_BIT] ||
                    ref_ctrl_r[atwrc_pkg::BIAS_BIT] ||
                    ref_ctrl_r[atwrc_pkg::BUF_BIT];

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      o_ref_level_sel   <= 1'b0;
      o_ref_source_sel  <= 1'b0;
      o_temp_sensor_on  <= 1'b0;
      o_bias_on         <= 1'b0;
      o_ref_buffer_on   <= 1'b0;
      o_zero_tc_bias_on <= 1'b0;
    end
    else
    begin
      o_ref_level_sel   <= ref_ctrl_r[atwrc_pkg::LV_BIT];
      o_ref_source_sel  <= ref_ctrl_r[atwrc_pkg::SL_BIT];
      o_temp_sensor_on  <= ref_ctrl_r[atwrc_pkg::TEMP_BIT];
      o_bias_on         <= ref_ctrl_r[atwrc_pkg::BIAS_BIT];
      o_ref_buffer_on   <= ref_ctrl_r[atwrc_pkg::BUF_BIT];
      // Software must force this on before oscillator suspend
      o_zero_tc_bias_on <= ref_ctrl_r[atwrc_pkg::ZTC_BIT] ||
                           ztc_need;
    end
  end

endmodule

`default_nettype wire

// ---- core/atwrc_pkg.sv ----
// Constants, field layouts and state encoding of the converter control block.
// Assumes an 8-bit register bus with one-cycle read latency and one clock.

package atwrc_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_TRACK_SEL = 8'hba;
  localparam logic [7:0] ADDR_REF_CTRL  = 8'hd1;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'he8;
  localparam logic [7:0] ADDR_UPPER_HI  = 8'hc4;
  localparam logic [7:0] ADDR_UPPER_LO  = 8'hc3;
  localparam logic [7:0] ADDR_LOWER_HI  = 8'hc6;
  localparam logic [7:0] ADDR_LOWER_LO  = 8'hc5;
  localparam logic [7:0] ADDR_RESULT_HI = 8'hbe;
  localparam logic [7:0] ADDR_RESULT_LO = 8'hbd;

  // ----------------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------------
  localparam logic [7:0]  TRACK_SEL_RST = 8'hff;
  localparam logic [7:0]  REF_CTRL_RST  = 8'h00;
  localparam logic [15:0] UPPER_RST     = 16'hffff;
  localparam logic [15:0] LOWER_RST     = 16'h0000;
  localparam logic [7:0]  REF_WR_MASK   = 8'h3f;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PWR_LSB   = 4;
  localparam int TM_LSB    = 2;
  localparam int TK_LSB    = 0;
  localparam int ZTC_BIT   = 5;
  localparam int LV_BIT    = 4;
  localparam int SL_BIT    = 3;
  localparam int TEMP_BIT  = 2;
  localparam int BIAS_BIT  = 1;
  localparam int BUF_BIT   = 0;
  localparam int EN_BIT    = 7;
  localparam int BURST_BIT = 6;
  localparam int BUSY_BIT  = 4;
  localparam int WIN_BIT   = 3;

  // ----------------------------------------------------------------------
  // Tracking modes
  // ----------------------------------------------------------------------
  localparam logic [1:0] TM_RSVD = 2'h0;
  localparam logic [1:0] TM_POST = 2'h1;
  localparam logic [1:0] TM_PRE  = 2'h2;
  localparam logic [1:0] TM_DUAL = 2'h3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 25;
  localparam int WAKE_UNIT_NS      = 200;
  localparam int WAKE_UNIT_CYC     =
    (WAKE_UNIT_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int POST_BASE_TICKS   = 2;
  localparam logic [7:0] POST_EXTRA_M1 = 8'h01;
  localparam logic [2:0] CONV_DIV_M1   = 3'h3;
  localparam logic [2:0] CONV_DIV_HALF = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAKE,
    ST_POST,
    ST_EXTRA,
    ST_CONV
  } atwrc_state_e;

endpackage

// ---- core/atwrc_seq_if.sv ----
// Interface between register file and conversion sequencer.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
`default_nettype none

interface atwrc_seq_if;
  logic       enable;
  logic       burst;
  logic [3:0] pwr_field;
  logic [1:0] tm_field;
  logic [1:0] tk_field;
  logic       conv_tick;
  logic       start;
  logic       done;
  logic       power_on;
  logic       track;
  logic       begin_conv;
  logic       busy;

  modport ctl (
    output enable, burst, pwr_field, tm_field, tk_field,
    output conv_tick, start, done,
    input  power_on, track, begin_conv, busy
  );
  modport seq (
    input  enable, burst, pwr_field, tm_field, tk_field,
    input  conv_tick, start, done,
    output power_on, track, begin_conv, busy
  );
endinterface

`default_nettype wire

// ---- core/atwrc_window.sv ----
// Window comparator with its sticky match flag.
// Assumes load is a one-cycle pulse carrying the result being stored.
`timescale 1ns/10ps
`default_nettype none

module atwrc_window (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // Result and limits
  input  wire logic        i_load,
  input  wire logic [15:0] i_result,
  input  wire logic [15:0] i_upper,
  input  wire logic [15:0] i_lower,
  // Software clear
  input  wire logic        i_clear,
  // Flag
  output var  logic        o_flag
);

  logic above;
  logic below;
  logic hit;

  assign above = i_result > i_upper;
  assign below = i_result < i_lower;
  // Lower above upper means an inside band, else an outside band
  assign hit = (i_lower > i_upper) ? (above & below)
                                   : (above | below);

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      o_flag <= 1'b0;
    else if (i_load && hit)
      o_flag <= 1'b1;
    else if (i_clear)
      o_flag <= 1'b0;
  end

endmodule

`default_nettype wire

// ---- core/atwrc_seq.sv ----
// Conversion sequencer: power state, burst wake-up and tracking.
// Assumes start and done are one-cycle pulses on the system clock.
`timescale 1ns/10ps
`default_nettype none

module atwrc_seq (
  // Clock and reset
  input  wire logic   i_sys_clk,
  input  wire logic   i_sys_rst,
  // Control and status
  atwrc_seq_if.seq    bus
);

  atwrc_pkg::atwrc_state_e state_r;
  atwrc_pkg::atwrc_state_e state_nxt;
  logic [7:0]              cnt_r;
  logic [7:0]              cnt_nxt;
  logic                    post_mode;
  logic                    pre_mode;
  logic                    sleeps;
  logic [7:0]              wake_m1;
  logic [7:0]              post_m1;

  assign post_mode = (bus.tm_field != atwrc_pkg::TM_PRE);
  assign pre_mode  = (bus.tm_field == atwrc_pkg::TM_PRE) ||
                     (bus.tm_field == atwrc_pkg::TM_DUAL);
  assign sleeps    = bus.burst && !bus.enable;
  assign wake_m1   = 8'((int'(bus.pwr_field) + 1) *
                        atwrc_pkg::WAKE_UNIT_CYC - 1);
  assign post_m1   = 8'((atwrc_pkg::POST_BASE_TICKS <<
                         bus.tk_field) - 1);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      atwrc_pkg::ST_IDLE:
        if (bus.start && (bus.enable || bus.burst))
        begin
          if (sleeps)
          begin
            state_nxt = atwrc_pkg::ST_WAKE;
            cnt_nxt   = wake_m1;
          end
          else if (post_mode)
          begin
            state_nxt = atwrc_pkg::ST_POST;
            cnt_nxt   = post_m1;
          end
          else
            state_nxt = atwrc_pkg::ST_CONV;
        end
      atwrc_pkg::ST_WAKE:
        if (cnt_r != 8'h00)
          cnt_nxt = cnt_r - 8'h01;
        else if (post_mode)
        begin
          state_nxt = atwrc_pkg::ST_POST;
          cnt_nxt   = post_m1;
        end
        else
          state_nxt = atwrc_pkg::ST_CONV;
      atwrc_pkg::ST_POST:
        if (bus.conv_tick)
        begin
          if (cnt_r != 8'h00)
            cnt_nxt = cnt_r - 8'h01;
          else
          begin
            state_nxt = atwrc_pkg::ST_EXTRA;
            cnt_nxt   = atwrc_pkg::POST_EXTRA_M1;
          end
        end
      atwrc_pkg::ST_EXTRA:
        if (cnt_r != 8'h00)
          cnt_nxt = cnt_r - 8'h01;
        else
          state_nxt = atwrc_pkg::ST_CONV;
      atwrc_pkg::ST_CONV:
        if (bus.done)
          state_nxt = atwrc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      state_r        <= atwrc_pkg::ST_IDLE;
      cnt_r          <= 8'h00;
      bus.power_on   <= 1'b0;
      bus.track      <= 1'b0;
      bus.begin_conv <= 1'b0;
      bus.busy       <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (!bus.burst)
        bus.power_on <= bus.enable;
      else if (bus.enable)
        bus.power_on <= 1'b1;
      else
        bus.power_on <= (state_nxt != atwrc_pkg::ST_IDLE);
      bus.track <= (state_nxt == atwrc_pkg::ST_POST) ||
                   (state_nxt == atwrc_pkg::ST_EXTRA) ||
                   ((state_nxt == atwrc_pkg::ST_IDLE) && pre_mode &&
                    bus.enable);
      bus.begin_conv <= (state_nxt == atwrc_pkg::ST_CONV) &&
                        (state_r != atwrc_pkg::ST_CONV);
      bus.busy <= (state_nxt != atwrc_pkg::ST_IDLE);
    end
  end

endmodule

`default_nettype wire

// ---- core/atwrc_seq_if_unused_guard.sv ----
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ---- bench/atwrc_assertions.sv ----
// Port-level checks of the converter control block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module atwrc_assertions (
  input wire logic       i_sys_clk,
  input wire logic       i_sys_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       i_conv_done,
  input wire logic       o_conv_power_on,
  input wire logic       o_conv_begin,
  input wire logic       o_window_flag,
  input wire logic       o_ref_level_sel,
  input wire logic       o_temp_sensor_on,
  input wire logic       o_zero_tc_bias_on
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  logic wref;
  logic wctl;
  assign wref = i_sfr_wr && i_sfr_addr == 8'hd1;
  assign wctl = i_sfr_wr && i_sfr_addr == 8'he8;

  rd_idle_a: assert property (!i_sfr_rd |=> o_sfr_rdata == 8'h00)
    else $error("read data not idle");
  ref_top_a: assert property
    (i_sfr_rd && i_sfr_addr == 8'hd1 |=> o_sfr_rdata[7:6] == 2'h0)
    else $error("reserved bits not zero");
  ref_level_a: assert property
    (wref |-> ##2 o_ref_level_sel == $past(i_sfr_wdata[4], 2))
    else $error("level select wrong");
  temp_on_a: assert property
    (wref |-> ##2 o_temp_sensor_on == $past(i_sfr_wdata[2], 2))
    else $error("temp sensor wrong");
  ztc_force_a: assert property
    (wref && i_sfr_wdata[5] |-> ##2 o_zero_tc_bias_on)
    else $error("bias not forced");
  plain_on_a: assert property
    (wctl && i_sfr_wdata[7:6] == 2'h2 |-> ##[1:3] o_conv_power_on)
    else $error("power not on");
  plain_off_a: assert property
    (wctl && i_sfr_wdata[7:6] == 2'h0 |-> ##[1:3] !o_conv_power_on)
    else $error("power not off");
  burst_on_a: assert property
    (wctl && i_sfr_wdata[7:6] == 2'h3 |-> ##3 o_conv_power_on [*8])
    else $error("burst power dropped");
  begin_pulse_a: assert property (o_conv_begin |=> !o_conv_begin)
    else $error("begin not a pulse");
  win_clear_a: assert property
    (wctl && !i_sfr_wdata[3] && !i_conv_done |-> ##2 !o_window_flag)
    else $error("flag not cleared");
  win_cause_a: assert property
    ($rose(o_window_flag) |-> $past(i_conv_done, 2))
    else $error("flag without result");
endmodule

bind atwrc_top atwrc_assertions chk_u (.i_sys_clk, .i_sys_rst, .i_sfr_addr,
  .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata, .i_conv_done,
  .o_conv_power_on, .o_conv_begin, .o_window_flag, .o_ref_level_sel,
  .o_temp_sensor_on, .o_zero_tc_bias_on);
`default_nettype wire

// ---- bench/atwrc_analog_model.sv ----
// Converter core model: answers each begin pulse with a held result.
// Assumes begin is a one-cycle pulse on the system clock.
`timescale 1ns/10ps
`default_nettype none

module atwrc_analog_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_begin,
  input  wire logic [15:0] i_value,
  output var  logic        o_done,
  output var  logic [15:0] o_result
);
  int cnt = 0;
  initial o_done = 1'b0;
  initial o_result = 16'h0000;
  // Result toggles when not held so stale data is never seen as valid
  always @(posedge i_sys_clk)
  begin
    cnt <= i_begin ? 1 : (cnt == 10 || cnt == 0) ? 0 : cnt + 1;
    o_done <= cnt >= 5 && cnt < 10;
    o_result <= (cnt >= 4 && cnt < 10) ? i_value : ~o_result;
  end
endmodule
`default_nettype wire

// ---- bench/adc_track_window_ref_ctrl_bench.sv ----
// Self-checking bench of the converter control block.
// Assumes the analog model answers each begin pulse.
`timescale 1ns/10ps
`default_nettype none

module adc_track_window_ref_ctrl_bench;
  logic clk = 0, rst = 1, wr = 0, rd = 0, st = 0, done, cclk, pwr, trk, beg;
  logic flag, lv, sl, te, bi, bu, zt;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  logic [15:0] val = 16'h0000, res;
  int errors = 0, cmp_count = 0, cyc = 0, a, b;
  always #12.5 clk = ~clk;
  atwrc_top dut_u (.i_sys_clk(clk), .i_sys_rst(rst), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wd), .o_sfr_rdata(rdata),
    .i_conv_start(st), .i_conv_done(done), .i_conv_result(res),
    .o_conv_clk(cclk), .o_conv_power_on(pwr), .o_conv_track(trk),
    .o_conv_begin(beg), .o_window_flag(flag), .o_ref_level_sel(lv),
    .o_ref_source_sel(sl), .o_temp_sensor_on(te), .o_bias_on(bi),
    .o_ref_buffer_on(bu), .o_zero_tc_bias_on(zt));
  atwrc_analog_model mdl_u (.i_sys_clk(clk), .i_begin(beg), .i_value(val),
    .o_done(done), .o_result(res));
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [15:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrr(input logic [7:0] ad, d);
    addr <= ad; wd <= d; wr <= 1; @(posedge clk);
    wr <= 0; repeat (3) @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] ad, e);
    addr <= ad; rd <= 1; @(posedge clk);
    rd <= 0; @(posedge clk); chk(rdata, e);
  endtask
  // Start on a fixed converter clock phase so tick-based counts repeat
  task automatic conv(output int n);
    @(posedge cclk);
    @(posedge clk);
    st <= 1;
    @(posedge clk);
    st <= 0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (beg !== 1'b1 && n < 900);
    chk(beg, 1'b1);
    repeat (20) @(posedge clk);
  endtask
  task automatic t_regs;
    rdc(8'hba, 8'hff); rdc(8'hd1, 8'h00); rdc(8'h10, 8'h00);
    wrr(8'hd1, 8'hff);
    rdc(8'hd1, 8'h3f);
    chk({lv, sl, te, bi, bu, zt}, 6'h3f);
    wrr(8'hd1, 8'h00);
    chk({lv, sl, te, bi, bu, zt}, 6'h00);
    // Converter clock is a quarter of the system clock, half high
    a = 0;
    repeat (8)
    begin
      @(posedge clk);
      a = a + int'(cclk);
    end
    chk(a, 4);
    $display("t_regs done");
  endtask
  task automatic t_track;
    wrr(8'he8, 8'h80); chk(pwr, 1'b1);
    chk(zt, 1'b1);
    wrr(8'hba, 8'hf4); chk(trk, 1'b0); conv(a);
    wrr(8'hba, 8'hf7); conv(b); chk(b - a, 56);
    wrr(8'hba, 8'hf8); chk(trk, 1'b1);
    wrr(8'hba, 8'hfc); chk(trk, 1'b1); chk(flag, 1'b0);
    $display("t_track done");
  endtask
  task automatic t_window;
    wrr(8'hc4, 8'h01); wrr(8'hc3, 8'h00); wrr(8'hc6, 8'h02); wrr(8'hc5, 8'h00);
    val <= 16'h0150; conv(a); chk(flag, 1'b1); rdc(8'hbd, 8'h50);
    rdc(8'he8, 8'h88); wrr(8'he8, 8'h80); chk(flag, 1'b0);
    val <= 16'h0250; conv(a); chk(flag, 1'b0);
    wrr(8'hc4, 8'h02); wrr(8'hc6, 8'h01);
    conv(a); chk(flag, 1'b1); wrr(8'he8, 8'h00);
    $display("t_window done");
  endtask
  task automatic t_burst;
    wrr(8'he8, 8'h40); wrr(8'hba, 8'h38); chk(pwr, 1'b0);
    conv(a); chk(pwr, 1'b0); wrr(8'hba, 8'h78); conv(b);
    chk(b - a, 32);
    wrr(8'he8, 8'hc0); conv(a); chk(pwr, 1'b1);
    $display("t_burst done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 0; @(posedge clk);
    t_regs; t_track; t_window; t_burst;
    tally_and_finish;
  end
endmodule
`default_nettype wire
